// ===== hdl/ugfm_mux.sv
// Upper GPIO pin function multiplexer with LCD pin driver and strap capture
`timescale 1ns/1ps
`include "ugfm_consts.svh"

module ugfm_mux
  import ugfm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [27:0] pin_option,
  input  wire logic [13:0] pad_in,
  output logic      [13:0] pad_out,
  output logic      [13:0] pad_oe,
  input  wire logic [13:0] gpio_out,
  input  wire logic [13:0] gpio_oe,
  output logic      [13:0] gpio_in,
  input  wire logic        txd_c,
  output logic             rxd_c,
  input  wire logic        rts_c,
  output logic             cts_c,
  input  wire logic        txd_d,
  output logic             rxd_d,
  input  wire logic        rts_d,
  output logic             cts_d,
  input  wire logic [4:0]  timer_out,
  input  wire logic [4:0]  timer_oe,
  output logic      [4:0]  timer_in,
  output logic             ext_irq3,
  input  wire logic [3:0]  par_data_out,
  input  wire logic [3:0]  par_data_oe,
  output logic      [3:0]  par_data_in,
  input  wire logic        par_select,
  output logic             par_nstrobe,
  output logic             par_nautofd,
  output logic             par_ninit,
  output logic             par_selectin,
  output logic             dma2_req,
  input  wire logic        dma2_done,
  input  wire logic        pad16_in,
  output logic             pad16_out,
  output logic             pad16_oe,
  input  wire logic        par_nfault,
  input  wire logic        par_nfault_oe,
  output logic             usb_overcurrent_input,
  input  wire logic        pad17_in,
  output logic             pad17_out,
  output logic             pad17_oe,
  input  wire logic        usb_power_on,
  output logic             pll_divider_strap,
  output logic             strap_done,
  input  wire logic [2:0]  lcd_mode,
  input  wire logic [23:0] tft_pixel_data,
  input  wire logic [7:0]  color_upper_panel_data,
  input  wire logic [7:0]  color_lower_panel_data,
  input  wire logic        lcd_power_req,
  input  wire logic        lcd_line_sync,
  input  wire logic        lcd_pixel_clock,
  input  wire logic        lcd_frame_sync,
  input  wire logic        lcd_ac_bias,
  input  wire logic        lcd_line_end,
  output logic             panel_power_enable,
  output logic             line_sync_pulse,
  output logic             panel_pixel_clock,
  output logic             frame_sync_pulse,
  output logic             ac_bias_data_enable,
  output logic             line_end_signal
);

  // ************************************************************
  // Synchronised pin inputs
  // ************************************************************
  logic [15:0] pin_sync;
  logic [13:0] s;
  ugfm_sync #(.WIDTH(`UGFM_SYNC_BITS)) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in ({pad17_in, pad16_in, pad_in}),
    .sync_out (pin_sync)
  );
  assign s = pin_sync[13:0];

  // ************************************************************
  // Option codes
  // ************************************************************
  // Held in flops so every pin switches on one clean edge
  logic [27:0] cfg;
  logic [13:0] hit0, hit1, hit2;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) cfg <= `UGFM_OPT_RESET;
    else       cfg <= pin_option;
  end

  // ************************************************************
  // LCD data formatting
  // ************************************************************
  logic [23:0] next_lcd, lcd_data;
  wire  [7:0]  up       = color_upper_panel_data;
  wire  [7:0]  lo       = color_lower_panel_data;
  wire         m_tft24  = lcd_mode == `UGFM_MODE_TFT24;
  wire         m_tft18  = lcd_mode == `UGFM_MODE_TFT18;
  wire         m_cstn_s = lcd_mode == `UGFM_MODE_CSTN_S;
  wire         m_cstn_d = lcd_mode == `UGFM_MODE_CSTN_D;
  wire         m_m4_s   = lcd_mode == `UGFM_MODE_M4_S;
  wire         m_m4_d   = lcd_mode == `UGFM_MODE_M4_D;
  wire         m_m8_s   = lcd_mode == `UGFM_MODE_M8_S;

  // Mono 4-bit panels use bits 3-0 of each panel byte, on lanes 3-0 (upper) and 11-8 (lower, dual only)
  assign next_lcd = m_tft24  ? tft_pixel_data :
                    m_tft18  ? {6'h00, tft_pixel_data[17:0]} :
                    m_cstn_s ? {16'h0000, up} :
                    m_cstn_d ? {8'h00, lo, up} :
                    m_m4_s   ? {20'h00000, up[3:0]} :
                    m_m4_d   ? {12'h000, lo[3:0], 4'h0, up[3:0]} :
                    m_m8_s   ? {16'h0000, up} :
                               {8'h00, lo, up};

  // ************************************************************
  // Per-function output tables, bit i is gpio[36+i]
  // ************************************************************
  logic [13:0] f0_out, f1_out, f2_out;
  logic [13:0] f0_oe, f1_oe, f2_oe;
  // Option 00 on pins 36-39 is reserved and leaves the pad undriven
  assign f0_out = {timer_out[4], timer_out[3], 1'b0, rts_d, 1'b0, txd_d, 1'b0, rts_c,
                   1'b0, txd_c, 4'h0};
  assign f0_oe  = {timer_oe[4], timer_oe[3], 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
                   1'b0, 1'b1, 4'h0};
  assign f1_out = {1'b1, 1'b0, 3'h0, par_select, timer_out[2:0], 1'b0,
                   par_data_out};
  assign f1_oe  = {1'b1, 1'b0, 3'h0, 1'b1, timer_oe[2:0], 1'b0,
                   par_data_oe};
  assign f2_out = {dma2_done, 1'b0, lcd_data[23:12]};
  assign f2_oe  = {1'b1, 1'b0, 12'hFFF};
  logic [13:0] next_pad_out, next_pad_oe;
  genvar i;
  generate
    for (i = 0; i < `UGFM_NPINS; i++) begin : g_pin
      wire [1:0] opt = cfg[2*i+1:2*i];
      assign hit0[i] = opt == `UGFM_OPT_FUNC0;
      assign hit1[i] = opt == `UGFM_OPT_FUNC1;
      assign hit2[i] = opt == `UGFM_OPT_FUNC2;
      assign next_pad_out[i] = hit0[i] ? f0_out[i] :
                               hit1[i] ? f1_out[i] :
                               hit2[i] ? f2_out[i] : gpio_out[i];
      assign next_pad_oe[i]  = hit0[i] ? f0_oe[i] :
                               hit1[i] ? f1_oe[i] :
                               hit2[i] ? f2_oe[i] : gpio_oe[i];
    end
  endgenerate

  // ************************************************************
  // Input routing; unselected inputs rest at their idle level
  // ************************************************************
  wire        n_rxd_c = hit0[5]  ? s[5]  : 1'b1;
  wire        n_cts_c = hit0[7]  ? s[7]  : 1'b1;
  wire        n_rxd_d = hit0[9]  ? s[9]  : 1'b1;
  wire        n_cts_d = hit0[11] ? s[11] : 1'b1;
  wire        n_irq3  = hit1[4]  & s[4];
  wire        n_nstb  = hit1[9]  ? s[9]  : 1'b1;
  wire        n_nafd  = hit1[10] ? s[10] : 1'b1;
  wire        n_nini  = hit1[11] ? s[11] : 1'b1;
  wire        n_seli  = hit1[12] ? s[12] : 1'b1;
  wire        n_dreq  = hit2[12] & s[12];
  wire [4:0]  n_tmr   = {hit0[13] & s[13], hit0[12] & s[12],
                         hit1[7] & s[7], hit1[6] & s[6], hit1[5] & s[5]};
  wire [3:0]  n_pdat  = hit1[3:0] & s[3:0];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pad_out      <= 14'h0000;
      pad_oe       <= 14'h0000;
      gpio_in      <= 14'h0000;
      lcd_data     <= 24'h000000;
      rxd_c        <= 1'b1;
      cts_c        <= 1'b1;
      rxd_d        <= 1'b1;
      cts_d        <= 1'b1;
      par_nstrobe  <= 1'b1;
      par_nautofd  <= 1'b1;
      par_ninit    <= 1'b1;
      par_selectin <= 1'b1;
      ext_irq3     <= 1'b0;
      dma2_req     <= 1'b0;
      timer_in     <= 5'h00;
      par_data_in  <= 4'h0;
    end else begin
      pad_out      <= next_pad_out;
      pad_oe       <= next_pad_oe;
      gpio_in      <= s;
      lcd_data     <= next_lcd;
      rxd_c        <= n_rxd_c;
      cts_c        <= n_cts_c;
      rxd_d        <= n_rxd_d;
      cts_d        <= n_cts_d;
      par_nstrobe  <= n_nstb;
      par_nautofd  <= n_nafd;
      par_ninit    <= n_nini;
      par_selectin <= n_seli;
      ext_irq3     <= n_irq3;
      dma2_req     <= n_dreq;
      timer_in     <= n_tmr;
      par_data_in  <= n_pdat;
    end
  end

  // ************************************************************
  // LCD control outputs
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      panel_power_enable  <= 1'b0;
      line_sync_pulse     <= 1'b0;
      panel_pixel_clock   <= 1'b0;
      frame_sync_pulse    <= 1'b0;
      ac_bias_data_enable <= 1'b0;
      line_end_signal     <= 1'b0;
    end else begin
      panel_power_enable  <= lcd_power_req;
      line_sync_pulse     <= lcd_line_sync;
      panel_pixel_clock   <= lcd_pixel_clock;
      frame_sync_pulse    <= lcd_frame_sync;
      ac_bias_data_enable <= lcd_ac_bias;
      line_end_signal     <= lcd_line_end;
    end
  end

  // ************************************************************
  // gpio16: nFault direction out, overcurrent in
  // ************************************************************
  // No filter here: a glitch on the overcurrent pin reaches software
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pad16_out             <= 1'b0;
      pad16_oe              <= 1'b0;
      usb_overcurrent_input <= 1'b0;
    end else begin
      pad16_out             <= par_nfault;
      pad16_oe              <= par_nfault_oe;
      usb_overcurrent_input <= pin_sync[14];
    end
  end

  // ************************************************************
  // gpio17 strap capture then power-switch enable
  // ************************************************************
  // The pad stays undriven until the strap is caught, so the external
  // pull sets both the strap level and the switch's idle state
  ugfm_state_t state, next_state;
  logic [1:0]  wait_cnt;
  wire         wait_done = wait_cnt == `UGFM_STRAP_WAIT;
  always_comb begin
    next_state = state;
    unique case (state)
      UGFM_ST_STRAP: if (wait_done) next_state = UGFM_ST_RUN;
      UGFM_ST_RUN:   next_state = UGFM_ST_RUN;
      default:       next_state = UGFM_ST_STRAP;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state             <= UGFM_ST_STRAP;
      wait_cnt          <= 2'h0;
      pll_divider_strap <= 1'b0;
      strap_done        <= 1'b0;
      pad17_out         <= 1'b0;
      pad17_oe          <= 1'b0;
    end else begin
      state    <= next_state;
      wait_cnt <= wait_done ? wait_cnt : wait_cnt + 2'h1;
      if (state == UGFM_ST_STRAP && wait_done) begin
        pll_divider_strap <= pin_sync[15];
        strap_done        <= 1'b1;
      end
      pad17_out <= usb_power_on;
      pad17_oe  <= state == UGFM_ST_RUN;
    end
  end

endmodule : ugfm_mux

// ===== hdl/ugfm_consts.svh
// Constants for the upper GPIO function multiplexer
`ifndef UGFM_CONSTS_SVH
`define UGFM_CONSTS_SVH

`define UGFM_NPINS        14
`define UGFM_SYNC_BITS    16
`define UGFM_OPT_FUNC0    2'h0
`define UGFM_OPT_FUNC1    2'h1
`define UGFM_OPT_FUNC2    2'h2
`define UGFM_OPT_GPIO     2'h3
`define UGFM_OPT_RESET    28'hFFFFFFF
`define UGFM_STRAP_WAIT   2'h3
`define UGFM_MODE_TFT24   3'h0
`define UGFM_MODE_TFT18   3'h1
`define UGFM_MODE_CSTN_S  3'h2
`define UGFM_MODE_CSTN_D  3'h3
`define UGFM_MODE_M4_S    3'h4
`define UGFM_MODE_M4_D    3'h5
`define UGFM_MODE_M8_S    3'h6
`define UGFM_MODE_M8_D    3'h7

`endif

// ===== hdl/ugfm_pkg.sv
// Types for the upper GPIO function multiplexer
package ugfm_pkg;

  typedef enum logic [1:0] {
    UGFM_ST_STRAP = 2'b01,
    UGFM_ST_RUN   = 2'b10
  } ugfm_state_t;

  typedef logic [2:0] ugfm_lcd_mode_t;

endpackage : ugfm_pkg

// ===== hdl/ugfm_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ugfm_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : ugfm_sync

// ===== testbench/ugfm_mux_sva.sv
// Port checker for the upper GPIO function multiplexer
`timescale 1ns/1ps
module ugfm_mux_sva (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [27:0] pin_option,
  input wire logic [13:0] pad_in,
  input wire logic [13:0] pad_out,
  input wire logic [13:0] pad_oe,
  input wire logic [13:0] gpio_out,
  input wire logic [13:0] gpio_oe,
  input wire logic        ext_irq3,
  input wire logic        par_nstrobe,
  input wire logic        rxd_d,
  input wire logic [2:0]  lcd_mode,
  input wire logic [23:0] tft_pixel_data,
  input wire logic [7:0]  color_lower_panel_data,
  input wire logic        par_nfault,
  input wire logic        par_nfault_oe,
  input wire logic        pad16_out,
  input wire logic        pad16_oe,
  input wire logic        pad17_in,
  input wire logic        pad17_out,
  input wire logic        pad17_oe,
  input wire logic        usb_power_on,
  input wire logic        pll_divider_strap,
  input wire logic        strap_done
);
  // ****************
  // Warm-up tracking
  // ****************
  logic [2:0] age;
  logic       live;
  // Three-deep history must not reach back into reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  assign live = (age > 3'h3);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_gpio_code_pass: assert property (live && $past(pin_option[1:0], 2) == 2'h3 |->
    pad_out[0] == $past(gpio_out[0]) && pad_oe[0] == $past(gpio_oe[0]))
    else $error("gpio code does not pass controller drive");
  a_reserved_no_drive: assert property (live && $past(pin_option[1:0], 2) == 2'h0 |->
    !pad_oe[0]) else $error("reserved code drives pad");
  a_tft_bit_route: assert property (live && $past(pin_option[1:0], 2) == 2'h2 &&
    $past(lcd_mode, 2) == 3'h0 |-> pad_out[0] == $past(tft_pixel_data[12], 2) && pad_oe[0])
    else $error("lcd bit 12 wrong in tft24");
  a_dual_lower_route: assert property (live && $past(pin_option[7:0], 2) == 8'hAA &&
    $past(lcd_mode, 2) == 3'h3 |-> pad_out[3:0] == $past(color_lower_panel_data[7:4], 2))
    else $error("lower panel data misplaced");
  a_irq_route: assert property (live && $past(pin_option[9:8], 2) == 2'h1 |->
    ext_irq3 == $past(pad_in[4], 3)) else $error("irq3 not from pad");
  a_host_strobe: assert property (live && $past(pin_option[19:18], 2) == 2'h1 |->
    par_nstrobe == $past(pad_in[9], 3) && !pad_oe[9]) else $error("strobe path wrong");
  a_idle_level: assert property (live && $past(pin_option[19:18], 2) == 2'h3 |->
    rxd_d && par_nstrobe) else $error("unselected input not idle high");
  a_const_high: assert property (live && $past(pin_option[27:26], 2) == 2'h1 |->
    pad_out[13] && pad_oe[13]) else $error("pin49 not held high");
  a_nfault_pol: assert property (live |-> pad16_out == $past(par_nfault) &&
    pad16_oe == $past(par_nfault_oe)) else $error("nfault altered");
  a_strap_seq: assert property ($rose(rstn) |-> (!strap_done && !pad17_oe)[*4] ##1
    (strap_done && !pad17_oe) ##1 pad17_oe) else $error("strap timing wrong");
  a_strap_value: assert property ($rose(strap_done) |->
    pll_divider_strap == $past(pad17_in, 3)) else $error("strap value wrong");
  a_usb_switch: assert property (live |-> pad17_out == $past(usb_power_on))
    else $error("power switch enable wrong");

  c_strap: cover property (strap_done && pad17_oe);
  c_irq: cover property (ext_irq3);
  c_dual: cover property (lcd_mode == 3'h3 && pad_oe[0]);
endmodule : ugfm_mux_sva

bind ugfm_mux ugfm_mux_sva chk_u (.*);

// ===== testbench/ugfm_far_end.sv
// Far-side model: host, peripherals, panel and strap resistor on the pads
`timescale 1ns/1ps
module ugfm_far_end (
  input  wire logic [13:0] pad_out,
  input  wire logic [13:0] pad_oe,
  input  wire logic [13:0] host_val,
  input  wire logic [13:0] host_en,
  input  wire logic        pad16_out,
  input  wire logic        pad16_oe,
  input  wire logic        pad17_out,
  input  wire logic        pad17_oe,
  input  wire logic        strap_level,
  input  wire logic        ovr_level,
  output logic      [13:0] pad_in,
  output logic             pad16_in,
  output logic             pad17_in
);
  // Pads have pull-ups, so a released line reads high
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & (~host_en | host_val));
  // Resistor holds the strap level until the switch enable is driven
  assign pad17_in = pad17_oe ? pad17_out : strap_level;
  // Overcurrent arrives already filtered by the power switch
  assign pad16_in = pad16_oe ? pad16_out : ovr_level;
endmodule : ugfm_far_end

// ===== testbench/tb_upper_gpio_function_mux.sv
// Self-checking bench for the upper GPIO function multiplexer
`timescale 1ns/1ps
module tb_upper_gpio_function_mux;
  logic        sys_clk, rstn, txd_c, rts_c, txd_d, rts_d, par_select, dma2_done;
  logic        rxd_c, cts_c, rxd_d, cts_d, ext_irq3, par_nstrobe, par_nautofd;
  logic        par_ninit, par_selectin, dma2_req, pad16_in, pad16_out, pad16_oe;
  logic        par_nfault, par_nfault_oe, usb_overcurrent_input, pad17_in, pad17_out;
  logic        pad17_oe, usb_power_on, pll_divider_strap, strap_done, lcd_power_req;
  logic        lcd_line_sync, lcd_pixel_clock, lcd_frame_sync, lcd_ac_bias, lcd_line_end;
  logic        panel_power_enable, line_sync_pulse, panel_pixel_clock, frame_sync_pulse;
  logic        ac_bias_data_enable, line_end_signal, strap_level, ovr_level;
  logic [27:0] pin_option;
  logic [13:0] pad_in, pad_out, pad_oe, gpio_out, gpio_oe, gpio_in, host_val, host_en;
  logic [4:0]  timer_out, timer_oe, timer_in;
  logic [3:0]  par_data_out, par_data_oe, par_data_in;
  logic [2:0]  lcd_mode;
  logic [23:0] tft_pixel_data, expd;
  logic [7:0]  color_upper_panel_data, color_lower_panel_data;
  int          errors, checks_done;

  ugfm_mux dut_u (.*);
  ugfm_far_end far_u (.*);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // *************
  // Bench helpers
  // *************
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // *********
  // Scenarios
  // *********
  task automatic do_reset(input logic lvl);
    strap_level = lvl;
    usb_power_on = lvl;
    rstn = 1'b0;
    step(2);
    chk("pad_oe in reset", 24'h0, pad_oe);
    chk("idle inputs in reset", 24'hF, {rxd_c, cts_c, par_nstrobe, par_selectin});
    rstn = 1'b1;
    // Bounded wait; the strap capture must land within a few cycles
    for (int i = 0; i < 20 && strap_done !== 1'b1; i++) step(1);
    if (strap_done !== 1'b1) begin
      errors++;
      $display("MISMATCH strap_done expected 1 seen %b", strap_done);
      summarize();
    end
    chk("strap", {23'h0, lvl}, pll_divider_strap);
    step(2);
    chk("switch enable", {22'h0, 1'b1, lvl}, {pad17_oe, pad17_out});
    usb_power_on = ~lvl;
    step(4);
    chk("switch on", {22'h0, ~lvl, lvl}, {pad17_out, pll_divider_strap});
  endtask : do_reset
  task automatic t_gpio;
    gpio_out = 14'h2A5A;
    gpio_oe = 14'h3FFF;
    step(3);
    chk("gpio drive", {10'h0, gpio_out}, pad_out);
    chk("gpio oe", 24'h3FFF, pad_oe);
    gpio_oe = 14'h0;
    host_val = 14'h1C63;
    host_en = 14'h3FFF;
    step(4);
    chk("gpio in", 24'h1C63, gpio_in);
  endtask : t_gpio
  task automatic t_par;
    gpio_oe = 14'h3FFF;
    pin_option = 28'hFFFFF00;
    step(3);
    chk("reserved oe", 24'h3FF0, pad_oe);
    chk("others kept", 24'h2A5, pad_out[13:4]);
    pin_option = 28'hFFFFF55;
    par_data_out = 4'hA;
    par_data_oe = 4'hF;
    step(3);
    chk("par data out", 24'hFA, {pad_oe[3:0], pad_out[3:0]});
    par_data_oe = 4'h0;
    host_val = 14'h0005;
    step(4);
    chk("par data in", 24'h5, par_data_in);
  endtask : t_par
  task automatic t_func0;
    pin_option = 28'h0;
    {txd_c, rts_c, txd_d, rts_d} = 4'h9;
    timer_out = 5'h08;
    timer_oe = 5'h18;
    host_val = 14'h0880;
    // Code change, pad release and two sync flops: inputs settle after five edges
    step(5);
    chk("func0 oe", 24'h3550, pad_oe);
    chk("func0 out", 24'h1410, pad_out & 14'h3550);
    chk("func0 in", 24'h5, {rxd_c, cts_c, rxd_d, cts_d});
    chk("timers 14 15 in", 24'h1, timer_in[4:3]);
  endtask : t_func0
  task automatic t_func1;
    pin_option = 28'h5555555;
    timer_out = 5'h02;
    timer_oe = 5'h02;
    par_select = 1'b1;
    host_val = 14'h1433;
    step(5);
    chk("func1 oe", 24'h2140, pad_oe);
    chk("func1 out", 24'h2140, pad_out & 14'h2140);
    chk("irq3", 24'h1, ext_irq3);
    chk("timers in", 24'h1, timer_in[2:0] & 3'h5);
    chk("host ctl", 24'h5, {par_nstrobe, par_nautofd, par_ninit, par_selectin});
    chk("par in", 24'h3, par_data_in);
  endtask : t_func1
  task automatic t_lcd;
    pin_option = 28'hAAAAAAA;
    tft_pixel_data = 24'hABCDEF;
    color_upper_panel_data = 8'h5A;
    color_lower_panel_data = 8'hC3;
    dma2_done = 1'b1;
    host_val = 14'h1000;
    for (int m = 0; m < 8; m++) begin
      lcd_mode = 3'(m);
      step(3);
      case (m)
        0: expd = tft_pixel_data;
        1: expd = {6'h0, tft_pixel_data[17:0]};
        2, 6: expd = {16'h0, color_upper_panel_data};
        4: expd = {20'h0, color_upper_panel_data[3:0]};
        5: expd = {12'h0, color_lower_panel_data[3:0], 4'h0, color_upper_panel_data[3:0]};
        default: expd = {8'h0, color_lower_panel_data, color_upper_panel_data};
      endcase
      chk("lcd data", {12'h0, expd[23:12]}, pad_out[11:0]);
    end
    chk("lcd oe", 24'h2FFF, pad_oe);
    chk("dma2", 24'h3, {dma2_req, pad_out[13]});
  endtask : t_lcd
  task automatic t_ctrl;
    for (int p = 0; p < 2; p++) begin
      {lcd_power_req, lcd_line_sync, lcd_pixel_clock} = p ? 3'h5 : 3'h2;
      {lcd_frame_sync, lcd_ac_bias, lcd_line_end} = p ? 3'h3 : 3'h4;
      step(1);
      chk("lcd ctl", p ? 24'h2B : 24'h14, {panel_power_enable, line_sync_pulse,
        panel_pixel_clock, frame_sync_pulse, ac_bias_data_enable, line_end_signal});
    end
  endtask : t_ctrl
  task automatic t_nfault;
    {par_nfault, par_nfault_oe} = 2'h3;
    step(2);
    chk("nfault hi", 24'h3, {pad16_out, pad16_oe});
    par_nfault = 1'b0;
    step(2);
    chk("nfault lo", 24'h1, {pad16_out, pad16_oe});
    par_nfault_oe = 1'b0;
    ovr_level = 1'b1;
    step(5);
    chk("overcurrent", 24'h1, usb_overcurrent_input);
  endtask : t_nfault

  initial begin
    errors = 0;
    checks_done = 0;
    pin_option = 28'hFFFFFFF;
    {gpio_out, gpio_oe, host_val, host_en} = 56'h0;
    {txd_c, rts_c, txd_d, rts_d, par_select, dma2_done, par_nfault, par_nfault_oe} = 8'h0;
    {timer_out, timer_oe, par_data_out, par_data_oe, lcd_mode} = 21'h0;
    {tft_pixel_data, color_upper_panel_data, color_lower_panel_data} = 40'h0;
    {lcd_power_req, lcd_line_sync, lcd_pixel_clock} = 3'h0;
    {lcd_frame_sync, lcd_ac_bias, lcd_line_end, ovr_level} = 4'h0;
    do_reset(1'b1);
    t_gpio();
    t_par();
    t_func0();
    t_func1();
    t_lcd();
    t_ctrl();
    t_nfault();
    do_reset(1'b0);
    summarize();
  end
endmodule : tb_upper_gpio_function_mux
